// >>> design/sarseq_core.sv
// sequencer for a 10-bit successive-approximation converter with cpu registers
// assumes one clock, synchronous cpu accesses and a synchronous comparator result
//
// Contract
// - enable bit keeps conversions running back to back in software mode
// - trigger source: software or external edge
// - conversion-time code sets conversion length
// - sampling length follows conversion-time code
// - software mode: start delay before sampling after enable
// - edge field selects none, fall, rise, both
// - channel code picks analog input
// - reset clears mode and channel registers
// - reset clears result register
// - sample selected input, then hold
// - first trial sets bit nine, half tap
// - next trials set lower bit, tap from bits
// - after ten trials copy result, raise request
// - standby stops conversion, registers stay writable
// - mode bit or byte writes, channel byte only
// - external trigger starts hardware conversions
// - hardware mode: one conversion per edge
// - channel write aborts, restarts per mode
// - enable write restarts; clearing stops at once
// - result 16 bits, value in top ten
`timescale 1ns/1ps
`default_nettype none
`include "sarseq_defs.svh"
module sarseq_core
(
   input  wire logic                         clk,
   input  wire logic                         rst,
   input  wire sarseq_pkg::sarseq_cpu_req_t  cpu_req,
   output logic [7:0]                        cpu_rdata,
   input  wire logic                         standby,
   input  wire logic                         external_trigger_in,
   input  wire logic                         comparator_gt,
   output sarseq_pkg::sarseq_analog_t        analog_ctl,
   output logic                              conversion_done_irq,
   output logic [15:0]                       conversion_result_reg
);
   import sarseq_pkg::*;
   ////////////////////////////////////////////////////////////////////////
   // register decode
   logic       mode_hit, chan_hit;
   logic [7:0] converter_mode_control_reg, converter_mode_control_next;
   logic [7:0] input_channel_select_reg, input_channel_select_next;
   logic       en_write, chan_write;
   logic       conversion_enable_bit, trigger_source_sel;
   logic [2:0] ctime;
   logic [1:0] edge_sel;

   assign mode_hit = cpu_req.wr && (cpu_req.addr == `SARSEQ_MODE_ADDR);
   assign chan_hit = cpu_req.wr && (cpu_req.addr == `SARSEQ_CHAN_ADDR);
   assign conversion_enable_bit = converter_mode_control_reg[`SARSEQ_ENABLE_BIT];
   assign trigger_source_sel    = converter_mode_control_reg[`SARSEQ_TRIGSRC_BIT];
   assign ctime    = converter_mode_control_reg[`SARSEQ_CTIME_HI:`SARSEQ_CTIME_LO];
   assign edge_sel = converter_mode_control_reg[`SARSEQ_EDGE_HI:`SARSEQ_EDGE_LO];

   // register write next values
   always_comb
   begin
      converter_mode_control_next = converter_mode_control_reg;
      input_channel_select_next   = input_channel_select_reg;
      en_write   = 1'b0;
      chan_write = 1'b0;
      if (mode_hit)
      begin
         if (cpu_req.bit_wr)
         begin
            converter_mode_control_next[cpu_req.bit_sel] = cpu_req.wdata[0];
            en_write = (cpu_req.bit_sel == 3'(`SARSEQ_ENABLE_BIT));
         end
         else
         begin
            converter_mode_control_next = cpu_req.wdata;
            en_write = 1'b1;
         end
      end
      if (chan_hit && !cpu_req.bit_wr)
      begin
         input_channel_select_next = {6'h00, cpu_req.wdata[1:0]};
         chan_write = 1'b1;
      end
   end

   // register storage
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         converter_mode_control_reg <= `SARSEQ_MODE_RESET;
         input_channel_select_reg   <= `SARSEQ_CHAN_RESET;
      end
      else
      begin
         converter_mode_control_reg <= converter_mode_control_next;
         input_channel_select_reg   <= input_channel_select_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // trigger synchroniser and edge detect
   logic [2:0] trig_reg, trig_next;
   logic       trig_edge;

   always_comb
   begin
      trig_next = {trig_reg[1:0], external_trigger_in};
   end
   always_ff @(posedge clk)
   begin
      if (rst)
         trig_reg <= 3'h0;
      else
         trig_reg <= trig_next;
   end

   // edge select from synchronised stages 1 and 2
   always_comb
   begin
      case (edge_sel)
         2'h1:    trig_edge = trig_reg[2] & ~trig_reg[1];
         2'h2:    trig_edge = ~trig_reg[2] & trig_reg[1];
         2'h3:    trig_edge = trig_reg[2] ^ trig_reg[1];
         default: trig_edge = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // timing lookup from conversion-time code
   logic [7:0] conv_len, samp_len, delay_len;
   always_comb
   begin
      case (ctime)
         3'h0:    begin conv_len = 8'h90; samp_len = 8'h14; end
         3'h1:    begin conv_len = 8'h78; samp_len = 8'h10; end
         3'h2:    begin conv_len = 8'h60; samp_len = 8'h0c; end
         3'h4:    begin conv_len = 8'h48; samp_len = 8'h0a; end
         3'h5:    begin conv_len = 8'h3c; samp_len = 8'h08; end
         3'h6:    begin conv_len = 8'h30; samp_len = 8'h06; end
         default: begin conv_len = 8'h90; samp_len = 8'h14; end
      endcase
      delay_len = ctime[2] ? `SARSEQ_DELAY_SHORT : `SARSEQ_DELAY_LONG;
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencer
   sarseq_state_t state_reg, state_next;
   logic [7:0]    cnt_reg, cnt_next;
   logic [7:0]    tcnt_reg, tcnt_next;
   logic [9:0]    successive_approx_reg, sar_next;
   logic [3:0]    bit_reg, bit_next;
   logic [15:0]   res_next;
   logic          done_next, done_reg;
   logic [7:0]    trial_len, trial_end;
   logic          restart;
   // even split over ten trials, the first trial takes the remainder
   assign trial_len = 8'((conv_len - samp_len) / 8'(`SARSEQ_NBITS));
   assign trial_end = (bit_reg == 4'h9) ? 8'(conv_len - samp_len - 8'(trial_len * 8'h09))
                                        : trial_len;
   assign restart   = en_write || chan_write;

   always_comb
   begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      tcnt_next  = tcnt_reg;
      sar_next   = successive_approx_reg;
      bit_next   = bit_reg;
      res_next   = conversion_result_reg;
      done_next  = 1'b0;
      if (standby || !converter_mode_control_next[`SARSEQ_ENABLE_BIT])
      begin
         state_next = SQ_IDLE;
      end
      else if (restart || state_reg == SQ_IDLE)
      begin
         cnt_next = 8'h00;
         state_next = converter_mode_control_next[`SARSEQ_TRIGSRC_BIT]
                      ? SQ_WAIT : SQ_DELAY;
      end
      else
      begin
         case (state_reg)
            SQ_WAIT:
            begin
               if (trig_edge)
               begin
                  cnt_next   = 8'h00;
                  state_next = SQ_SAMPLE;
               end
            end
            SQ_DELAY:
            begin
               cnt_next = cnt_reg + 8'h01;
               if (cnt_reg + 8'h01 >= delay_len)
               begin
                  cnt_next   = 8'h00;
                  state_next = SQ_SAMPLE;
               end
            end
            SQ_SAMPLE:
            begin
               cnt_next = cnt_reg + 8'h01;
               if (cnt_reg + 8'h01 >= samp_len)
               begin
                  cnt_next   = 8'h00;
                  tcnt_next  = 8'h00;
                  bit_next   = 4'h9;
                  sar_next   = 10'h200;
                  state_next = SQ_TRIAL;
               end
            end
            SQ_TRIAL:
            begin
               tcnt_next = tcnt_reg + 8'h01;
               if (tcnt_reg + 8'h01 >= trial_end)
               begin
                  tcnt_next = 8'h00;
                  // keep bit when input at or above tap
                  sar_next[bit_reg] = comparator_gt;
                  if (bit_reg == 4'h0)
                  begin
                     res_next  = {sar_next, 6'h00};
                     done_next = 1'b1;
                     cnt_next  = 8'h00;
                     // software mode repeats, hardware waits
                     state_next = trigger_source_sel ? SQ_WAIT : SQ_SAMPLE;
                  end
                  else
                  begin
                     bit_next = bit_reg - 4'h1;
                     sar_next[bit_reg - 4'h1] = 1'b1;
                  end
               end
            end
            default: state_next = SQ_IDLE;
         endcase
      end
   end
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_reg             <= SQ_IDLE;
         cnt_reg               <= 8'h00;
         tcnt_reg              <= 8'h00;
         successive_approx_reg <= 10'h000;
         bit_reg               <= 4'h0;
         conversion_result_reg <= `SARSEQ_RES_RESET;
         done_reg              <= 1'b0;
      end
      else
      begin
         state_reg             <= state_next;
         cnt_reg               <= cnt_next;
         tcnt_reg              <= tcnt_next;
         successive_approx_reg <= sar_next;
         bit_reg               <= bit_next;
         conversion_result_reg <= res_next;
         done_reg              <= done_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign conversion_done_irq = done_reg;
   assign analog_ctl = '{chan:   input_channel_select_reg[`SARSEQ_CHAN_HI:`SARSEQ_CHAN_LO],
                         sample: (state_reg == SQ_SAMPLE),
                         hold:   (state_reg == SQ_TRIAL),
                         tap:    successive_approx_reg};
   // cpu read mux
   always_comb
   begin
      case (cpu_req.addr)
         `SARSEQ_MODE_ADDR:   cpu_rdata = converter_mode_control_reg;
         `SARSEQ_CHAN_ADDR:   cpu_rdata = input_channel_select_reg;
         `SARSEQ_RES_ADDR_LO: cpu_rdata = conversion_result_reg[7:0];
         `SARSEQ_RES_ADDR_HI: cpu_rdata = conversion_result_reg[15:8];
         default:             cpu_rdata = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   property p_reset_clear;
      @(posedge clk) rst |=> (converter_mode_control_reg == 8'h00)
         && (input_channel_select_reg == 8'h00) && (conversion_result_reg == 16'h0000);
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("reset clear failed");
   property p_low_zero;
      @(posedge clk) disable iff (rst) conversion_result_reg[5:0] == 6'h00;
   endproperty
   a_low_zero: assert property (p_low_zero) else $error("result low bits set");
   property p_done_pulse;
      @(posedge clk) disable iff (rst) conversion_done_irq |=> !conversion_done_irq;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");
   property p_done_result;
      @(posedge clk) disable iff (rst)
         conversion_done_irq |-> conversion_result_reg[15:6] == successive_approx_reg;
   endproperty
   a_done_result: assert property (p_done_result) else $error("result not copied");
   property p_stop;
      @(posedge clk) disable iff (rst)
         !conversion_enable_bit |-> state_reg == SQ_IDLE;
   endproperty
   a_stop: assert property (p_stop) else $error("runs while disabled");
   property p_standby;
      @(posedge clk) disable iff (rst) standby |=> !analog_ctl.sample && !analog_ctl.hold;
   endproperty
   a_standby: assert property (p_standby) else $error("runs in standby");
   sequence s_sample_end;
      analog_ctl.sample ##1 analog_ctl.hold;
   endsequence
   property p_first_trial;
      @(posedge clk) disable iff (rst) s_sample_end |-> successive_approx_reg == 10'h200;
   endproperty
   a_first_trial: assert property (p_first_trial) else $error("first trial wrong");
   property p_hw_wait;
      @(posedge clk) disable iff (rst)
         (state_reg == SQ_WAIT && !trig_edge && !restart && conversion_enable_bit
          && !standby) |=> state_reg == SQ_WAIT;
   endproperty
   a_hw_wait: assert property (p_hw_wait) else $error("start without edge");
endmodule : sarseq_core
`default_nettype wire

// >>> design/sarseq_defs.svh
// constants for the converter sequencer: offsets, fields, reset values, timing
// assumes inclusion by bare name from the package and the design module
`ifndef SARSEQ_DEFS_SVH
`define SARSEQ_DEFS_SVH
`define SARSEQ_MODE_ADDR      16'hff80
`define SARSEQ_CHAN_ADDR      16'hff81
`define SARSEQ_RES_ADDR_LO    16'hff16
`define SARSEQ_RES_ADDR_HI    16'hff17
`define SARSEQ_MODE_RESET     8'h00
`define SARSEQ_CHAN_RESET     8'h00
`define SARSEQ_RES_RESET      16'h0000
`define SARSEQ_ENABLE_BIT     7
`define SARSEQ_TRIGSRC_BIT    6
`define SARSEQ_CTIME_HI       5
`define SARSEQ_CTIME_LO       3
`define SARSEQ_EDGE_HI        2
`define SARSEQ_EDGE_LO        1
`define SARSEQ_CHAN_HI        1
`define SARSEQ_CHAN_LO        0
`define SARSEQ_RES_SHIFT      6
`define SARSEQ_NBITS          10
// start delay in main-clock periods, long and short code groups
`define SARSEQ_DELAY_LONG     8'h07
`define SARSEQ_DELAY_SHORT    8'h04
`endif

// >>> design/sarseq_pkg.sv
// types for the converter sequencer
// assumes the constant header sits beside it
`include "sarseq_defs.svh"
package sarseq_pkg;
   // one-hot sequencer states
   typedef enum logic [4:0] {
      SQ_IDLE   = 5'b0_0001,
      SQ_WAIT   = 5'b0_0010,
      SQ_DELAY  = 5'b0_0100,
      SQ_SAMPLE = 5'b0_1000,
      SQ_TRIAL  = 5'b1_0000
   } sarseq_state_t;
   // cpu register access
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic        bit_wr;
      logic [2:0]  bit_sel;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } sarseq_cpu_req_t;
   // analog front-end controls
   typedef struct packed {
      logic [1:0] chan;
      logic       sample;
      logic       hold;
      logic [9:0] tap;
   } sarseq_analog_t;
endpackage : sarseq_pkg

// >>> test/sarseq_afe_model.sv
// analog front end model: four fixed input levels, sample-hold, comparator
// assumes the tap follows the approximation register and is compared at once
`timescale 1ns/1ps
`default_nettype none
module sarseq_afe_model
#(
   parameter logic [9:0] V0 = 10'h155,
   parameter logic [9:0] V1 = 10'h2aa,
   parameter logic [9:0] V2 = 10'h3ff,
   parameter logic [9:0] V3 = 10'h001
)
(
   input  wire logic                       clk,
   input  wire sarseq_pkg::sarseq_analog_t analog_ctl,
   output logic                            comparator_gt
);
   import sarseq_pkg::*;
   logic [9:0] held_reg;
   logic [9:0] vin;
   ////////////////////////////////////////////////////////////////////////////
   // input selector
   always_comb
   begin
      case (analog_ctl.chan)
         2'h0:    vin = V0;
         2'h1:    vin = V1;
         2'h2:    vin = V2;
         default: vin = V3;
      endcase
   end
   // track while sampling, keep the level otherwise
   initial held_reg = 10'h000;
   always @(posedge clk)
   begin
      if (analog_ctl.sample) held_reg <= vin;
   end
   // input at or above the tap keeps the trial bit
   assign comparator_gt = (held_reg >= analog_ctl.tap);
endmodule : sarseq_afe_model
`default_nettype wire

// >>> test/tb.sv
// self-checking bench for the converter sequencer
// assumes the front end model and the design package are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
   import sarseq_pkg::*;
   localparam logic [9:0] V2 = 10'h3ff;
   localparam logic [9:0] V3 = 10'h001;
   logic            clk;
   logic            rst;
   logic            standby;
   logic            trig;
   logic            gt;
   logic            done;
   logic [7:0]      rdata;
   logic [15:0]     res;
   sarseq_cpu_req_t req;
   sarseq_analog_t  actl;
   int              n_fail;
   int              comparisons;
   int              per;
   int              smp;
   sarseq_core sarseq_core_inst (
      .clk(clk), .rst(rst), .cpu_req(req), .cpu_rdata(rdata), .standby(standby),
      .external_trigger_in(trig), .comparator_gt(gt), .analog_ctl(actl),
      .conversion_done_irq(done), .conversion_result_reg(res));
   sarseq_afe_model #(.V2(V2), .V3(V3)) sarseq_afe_model_inst (
      .clk(clk), .analog_ctl(actl), .comparator_gt(gt));
   ////////////////////////////////////////////////////////////////////////////
   // clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // verdict and exit
   task automatic end_sim;
      $display("n_fail %0d comparisons %0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_sim
   // compare one value
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // register write, byte or single bit
   task automatic wr(input logic [15:0] a, input logic [7:0] d,
                     input logic b = 1'b0, input logic [2:0] s = 3'h0);
      @(negedge clk);
      req = '{wr: 1'b1, rd: 1'b0, bit_wr: b, bit_sel: s, addr: a, wdata: d};
      @(negedge clk);
      req.wr = 1'b0;
      req.bit_wr = 1'b0;
   endtask : wr
   // register read and compare
   task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
      req.addr = a;
      req.rd = 1'b1;
      #1;
      check({8'h00, rdata}, {8'h00, exp});
      req.rd = 1'b0;
   endtask : rdc
   // wait for n done pulses; period and sample length of the last one
   task automatic wdone(input int n);
      int c;
      int k;
      int s;
      c = 0;
      k = 0;
      s = 0;
      while (k < n)
      begin
         @(negedge clk);
         c++;
         if (actl.sample === 1'b1) s++;
         if (done === 1'b1)
         begin
            k++;
            per = c;
            smp = s;
            c = 0;
            s = 0;
         end
         if (c > 2000)
         begin
            check(16'h0000, 16'h0001);
            end_sim;
         end
      end
   endtask : wdone
   // count done pulses over n cycles
   task automatic quiet(input int n, output int k);
      k = 0;
      repeat (n)
      begin
         @(negedge clk);
         if (done === 1'b1) k++;
      end
   endtask : quiet
   ////////////////////////////////////////////////////////////////////////////
   // reset values and unmapped read
   task automatic t_reset;
      rdc(16'hff80, 8'h00);
      rdc(16'hff81, 8'h00);
      rdc(16'hff16, 8'h00);
      rdc(16'hff17, 8'h00);
      rdc(16'h1234, 8'h00);
   endtask : t_reset
   // reset just after standby is released in software mode, with enable set, clears registers and result
   task automatic t_rerst;
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      t_reset;
   endtask : t_rerst
   // software start over the six time codes other than 3 and 7
   task automatic t_soft;
      int cv[6] = '{144, 120, 96, 72, 60, 48};
      int sv[6] = '{20, 16, 12, 10, 8, 6};
      logic [2:0] cd[6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
      int c;
      wr(16'hff81, 8'h02);
      for (int i = 0; i < 6; i++)
      begin
         wr(16'hff80, 8'h00);
         wr(16'hff80, {2'b10, cd[i], 3'b000});
         c = 0;
         while (actl.sample !== 1'b1 && c < 50)
         begin
            @(negedge clk);
            c++;
         end
         check(16'(i < 3 ? (c >= 6 && c <= 9) : (c >= 3 && c <= 6)), 16'h0001);
         if (c >= 50) end_sim;
         wdone(2);
         check(16'(per), 16'(cv[i]));
         check(16'(smp), 16'(sv[i]));
         check(res, {V2, 6'h00});
      end
      rdc(16'hff17, V2[9:2]);
      rdc(16'hff16, {V2[1:0], 6'h00});
   endtask : t_soft
   // bit writes, channel abort, standby and halt
   task automatic t_ctl;
      int k;
      wr(16'hff80, 8'h00);
      quiet(300, k);
      check(16'(k), 16'h0000);
      wr(16'hff80, 8'h01, 1'b1, 3'h7);
      rdc(16'hff80, 8'h80);
      wr(16'hff81, 8'h01, 1'b1, 3'h0);
      rdc(16'hff81, 8'h02);
      repeat (60) @(negedge clk);
      wr(16'hff81, 8'h03);
      check({14'h0000, actl.chan}, 16'h0003);
      wdone(1);
      check(res, {V3, 6'h00});
      check(16'(per >= 150 && per <= 152), 16'h0001);
      standby = 1'b1;
      quiet(400, k);
      check(16'(k), 16'h0000);
      standby = 1'b0;
   endtask : t_ctl
   // hardware start for every edge selection
   task automatic t_hw;
      int k;
      int a;
      for (int e = 0; e < 4; e++)
      begin
         wr(16'hff80, 8'h00);
         wr(16'hff80, 8'hc0 | 8'(e << 1));
         quiet(300, k);
         check(16'(k), 16'h0000);
         trig = 1'b1;
         quiet(400, k);
         trig = 1'b0;
         quiet(400, a);
         check(16'(k), 16'(e == 2 || e == 3));
         check(16'(a), 16'(e == 1 || e == 3));
      end
   endtask : t_hw
   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      n_fail = 0;
      comparisons = 0;
      rst = 1'b1;
      standby = 1'b0;
      trig = 1'b0;
      req = '0;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      t_reset;
      t_soft;
      t_ctl;
      t_rerst;
      t_hw;
      end_sim;
   end
endmodule : tb
`default_nettype wire
